//--- pin_load_model.sv
`timescale 1ns/1ps

module pin_load_model (
    // clock
    input wire logic mclk,
    // driven pin
    input wire logic pin,
    input wire logic oe_n,
    // measurement
    input wire logic clear_count,
    output logic wire_level,
    output int unsigned high_count
);
    logic last_level = 1'b0;

    // no pull on this net: a released pin shows the inverse of its last level
    assign wire_level = oe_n ? !last_level : pin;

    always @(posedge mclk)
    begin
        last_level <= wire_level;
        if (clear_count)
            high_count <= 0;
        else if (wire_level === 1'b1)
            high_count <= high_count + 1;
    end
endmodule : pin_load_model

//--- timer8_pkg.sv
package timer8_pkg;

    // register placement in the I/O space
    localparam logic [7:0] ADDR_COMPARE = 8'h23;
    localparam logic [7:0] ADDR_COUNTER = 8'h24;
    localparam logic [7:0] ADDR_CONTROL = 8'h25;
    localparam logic [7:0] IO_SPACE_LAST = 8'h3F;
    localparam logic [7:0] DATA_SPACE_OFFSET = 8'h20;

    // reset values
    localparam logic [7:0] COMPARE_RESET = 8'h00;
    localparam logic [7:0] COUNTER_RESET = 8'h00;
    localparam logic [7:0] CONTROL_RESET = 8'h00;

    // control register fields
    localparam int FOC_BIT = 7;
    localparam int WAVE_LOW_BIT = 6;
    localparam int COM_HI = 5;
    localparam int COM_LO = 4;
    localparam int WAVE_HIGH_BIT = 3;
    localparam int CS_HI = 2;
    localparam int CS_LO = 0;
    localparam logic [7:0] FOC_MASK = 8'h80;

    // counter limits
    localparam logic [7:0] COUNT_MAX = 8'hFF;
    localparam logic [7:0] COUNT_BOTTOM = 8'h00;
    localparam logic [7:0] COUNT_STEP = 8'h01;

    // clock select codes and prescaler masks
    localparam logic [2:0] CS_STOP = 3'h0;
    localparam logic [2:0] CS_DIV1 = 3'h1;
    localparam logic [2:0] CS_DIV8 = 3'h2;
    localparam logic [2:0] CS_DIV32 = 3'h3;
    localparam logic [2:0] CS_DIV64 = 3'h4;
    localparam logic [2:0] CS_DIV128 = 3'h5;
    localparam logic [2:0] CS_DIV256 = 3'h6;
    localparam logic [2:0] CS_DIV1024 = 3'h7;
    localparam logic [9:0] MASK_DIV8 = 10'h007;
    localparam logic [9:0] MASK_DIV32 = 10'h01F;
    localparam logic [9:0] MASK_DIV64 = 10'h03F;
    localparam logic [9:0] MASK_DIV128 = 10'h07F;
    localparam logic [9:0] MASK_DIV256 = 10'h0FF;
    localparam logic [9:0] MASK_DIV1024 = 10'h3FF;
    localparam logic [9:0] PRESCALE_STEP = 10'h001;

    // output actions, equal to the compare output mode codes of non-PWM modes
    localparam logic [1:0] ACT_NONE = 2'h0;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    localparam logic [1:0] ACT_CLEAR = 2'h2;
    localparam logic [1:0] ACT_SET = 2'h3;

    // index of each register in the holding and busy arrays
    localparam int HOLD_OCR = 0;
    localparam int HOLD_CNT = 1;
    localparam int HOLD_CTRL = 2;
    localparam int HOLD_REGS = 3;

    typedef enum logic [3:0] {
        MODE_NORMAL = 4'b0001,
        MODE_PHASE = 4'b0010,
        MODE_CTC = 4'b0100,
        MODE_FAST = 4'b1000
    } wave_mode_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic io_space;
        logic [7:0] addr;
        logic [7:0] wdata;
    } bus_req_t;

    typedef struct packed {
        logic [7:0] cnt;
        logic down;
        logic [7:0] ocr_buf;
        logic [7:0] ocr_act;
        logic [7:0] ctrl;
        logic block;
        logic oc;
        logic [9:0] pre;
        logic [2:0] xs;
        logic xlevel;
        logic [HOLD_REGS-1:0][7:0] hold;
        logic [HOLD_REGS-1:0][1:0] busy_cnt;
        logic [HOLD_REGS-1:0] busy;
        logic [7:0] rd_data;
        logic pin_out;
        logic pin_oe_n;
        logic cmp_evt;
        logic ovf_evt;
    } timer_state_t;

endpackage : timer8_pkg

//--- timer8_pwm_compare.sv
`timescale 1ns/1ps

module timer8_pwm_compare #(
    parameter int unsigned XFER_EDGES = 2
) (
    // clock, reset, enable
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic clk_en,
    // register access
    input wire timer8_pkg::bus_req_t io_req,
    output logic [7:0] rd_data,
    // clock source
    input wire logic async_clock_select,
    input wire logic crystal_clock_pin,
    // pin and port
    input wire logic port_data,
    input wire logic port_dir,
    output logic compare_output_pin,
    output logic compare_output_oe_n,
    // events and status
    output logic compare_match_event,
    output logic overflow_event,
    output logic counter_update_busy,
    output logic compare_update_busy,
    output logic control_update_busy
);
    import timer8_pkg::*;

    if (XFER_EDGES < 1 || XFER_EDGES > 3)
    begin : g_bad_xfer
        $error("XFER_EDGES must be 1 to 3");
    end

    localparam logic [1:0] XFER_LOAD = 2'(XFER_EDGES);
    localparam logic [1:0] XFER_LAST = 2'h1;
    timer_state_t s;
    timer_state_t n;
    // one-hot register hit for I/O or data space addresses
    function automatic logic [HOLD_REGS-1:0] reg_hit(input bus_req_t r);
        logic [7:0] a;
        logic [HOLD_REGS-1:0] h;
        a = r.io_space ? r.addr : r.addr - DATA_SPACE_OFFSET;
        h = '0;
        if ((r.io_space || r.addr >= DATA_SPACE_OFFSET) && a <= IO_SPACE_LAST)
        begin
            h[HOLD_OCR] = (a == ADDR_COMPARE);
            h[HOLD_CNT] = (a == ADDR_COUNTER);
            h[HOLD_CTRL] = (a == ADDR_CONTROL);
        end
        return h;
    endfunction : reg_hit
    function automatic wave_mode_t decode_mode(input logic [7:0] c);
        wave_mode_t m;
        unique case ({c[WAVE_HIGH_BIT], c[WAVE_LOW_BIT]})
            2'b00: m = MODE_NORMAL;
            2'b01: m = MODE_PHASE;
            2'b10: m = MODE_CTC;
            2'b11: m = MODE_FAST;
        endcase
        return m;
    endfunction : decode_mode
    function automatic logic presc_tick(input logic [2:0] cs, input logic [9:0] pre);
        logic [9:0] m;
        logic t;
        m = '0;
        t = 1'b0;
        unique case (cs)
            CS_STOP: t = 1'b0;
            CS_DIV1: t = 1'b1;
            CS_DIV8: m = MASK_DIV8;
            CS_DIV32: m = MASK_DIV32;
            CS_DIV64: m = MASK_DIV64;
            CS_DIV128: m = MASK_DIV128;
            CS_DIV256: m = MASK_DIV256;
            CS_DIV1024: m = MASK_DIV1024;
        endcase
        if (cs != CS_STOP && cs != CS_DIV1)
        begin
            t = ((pre & m) == m);
        end
        return t;
    endfunction : presc_tick
    function automatic logic apply_action(input logic oc, input logic [1:0] act);
        logic r;
        unique case (act)
            ACT_NONE: r = oc;
            ACT_TOGGLE: r = ~oc;
            ACT_CLEAR: r = 1'b0;
            ACT_SET: r = 1'b1;
        endcase
        return r;
    endfunction : apply_action
    logic [HOLD_REGS-1:0] hit;
    logic [HOLD_REGS-1:0] apply;
    logic [HOLD_REGS-1:0][7:0] val;
    logic xedge;
    logic src_tick;
    logic tick;
    logic match;
    logic force_now;
    logic [1:0] act;
    logic [1:0] fact;
    logic [1:0] com;
    logic [7:0] top;
    wave_mode_t mode;
    wave_mode_t fmode;

    always_comb
    begin
        n = s;
        n.cmp_evt = 1'b0;
        n.ovf_evt = 1'b0;
        hit = reg_hit(io_req);
        // crystal pin: three stages, level accepted when stages two and three agree
        n.xs = {s.xs[1:0], crystal_clock_pin};
        if (s.xs[2] == s.xs[1])
        begin
            n.xlevel = s.xs[1];
        end
        xedge = s.xs[2] & s.xs[1] & ~s.xlevel;
        src_tick = async_clock_select ? xedge : 1'b1;
        if (src_tick)
        begin
            n.pre = s.pre + PRESCALE_STEP;
        end
        tick = src_tick && presc_tick(s.ctrl[CS_HI:CS_LO], s.pre);
        mode = decode_mode(s.ctrl);
        com = s.ctrl[COM_HI:COM_LO];
        top = (mode == MODE_CTC) ? s.ocr_act : COUNT_MAX;
        match = (s.cnt == s.ocr_act) && !s.block;
        act = ACT_NONE;
        if (tick)
        begin
            n.block = 1'b0;
            n.cmp_evt = match;
            unique case (mode)
                MODE_NORMAL:
                begin
                    n.cnt = s.cnt + COUNT_STEP;
                    n.ovf_evt = (s.cnt == COUNT_MAX);
                    if (match)
                    begin
                        act = com;
                    end
                end
                MODE_CTC:
                begin
                    n.cnt = (s.cnt == top) ? COUNT_BOTTOM : s.cnt + COUNT_STEP;
                    n.ovf_evt = (s.cnt == COUNT_MAX);
                    if (match)
                    begin
                        act = com;
                    end
                end
                MODE_FAST:
                begin
                    n.cnt = s.cnt + COUNT_STEP;
                    if (s.cnt == COUNT_MAX)
                    begin
                        n.ovf_evt = 1'b1;
                        n.ocr_act = s.ocr_buf;
                        // a match at top is dropped in favour of the bottom action
                        if (com[1])
                        begin
                            act = com[0] ? ACT_CLEAR : ACT_SET;
                        end
                    end
                    else if (match && com[1])
                    begin
                        act = com[0] ? ACT_SET : ACT_CLEAR;
                    end
                end
                MODE_PHASE:
                begin
                    if (!s.down)
                    begin
                        if (s.cnt == COUNT_MAX)
                        begin
                            n.down = 1'b1;
                            n.cnt = s.cnt - COUNT_STEP;
                            n.ocr_act = s.ocr_buf;
                        end
                        else
                        begin
                            n.cnt = s.cnt + COUNT_STEP;
                        end
                    end
                    else if (s.cnt == COUNT_BOTTOM)
                    begin
                        n.down = 1'b0;
                        n.cnt = s.cnt + COUNT_STEP;
                        n.ovf_evt = 1'b1;
                    end
                    else
                    begin
                        n.cnt = s.cnt - COUNT_STEP;
                    end
                    // compare at top only matches once, on the turn, so it acts at top
                    if (match && com[1])
                    begin
                        act = (com[0] ^ s.down) ? ACT_SET : ACT_CLEAR;
                    end
                end
            endcase
        end
        // register updates: direct when synchronous, after transfer when asynchronous
        for (int i = 0; i < HOLD_REGS; i++)
        begin
            if (async_clock_select)
            begin
                apply[i] = xedge && (s.busy_cnt[i] == XFER_LAST);
                val[i] = s.hold[i];
                if (xedge && s.busy_cnt[i] != 2'h0)
                begin
                    n.busy_cnt[i] = s.busy_cnt[i] - XFER_LAST;
                end
                if (io_req.wr && hit[i])
                begin
                    n.hold[i] = io_req.wdata;
                    n.busy_cnt[i] = XFER_LOAD;
                end
            end
            else
            begin
                apply[i] = io_req.wr && hit[i];
                val[i] = io_req.wdata;
                n.busy_cnt[i] = 2'h0;
            end
            n.busy[i] = (n.busy_cnt[i] != 2'h0);
        end
        force_now = 1'b0;
        if (apply[HOLD_OCR])
        begin
            n.ocr_buf = val[HOLD_OCR];
        end
        if (apply[HOLD_CNT])
        begin
            n.cnt = val[HOLD_CNT];
            n.block = 1'b1;
        end
        if (apply[HOLD_CTRL])
        begin
            n.ctrl = val[HOLD_CTRL] & ~FOC_MASK;
            force_now = val[HOLD_CTRL][FOC_BIT];
        end
        fmode = decode_mode(n.ctrl);
        if (fmode == MODE_NORMAL || fmode == MODE_CTC)
        begin
            n.ocr_act = n.ocr_buf;
        end
        // forced compare only moves the output; event and counter stay untouched
        fact = ACT_NONE;
        if (force_now && (fmode == MODE_NORMAL || fmode == MODE_CTC))
        begin
            fact = n.ctrl[COM_HI:COM_LO];
        end
        n.oc = apply_action(apply_action(s.oc, act), fact);
        // reads: live counter, held compare and control while asynchronous
        if (io_req.rd)
        begin
            n.rd_data = '0;
            if (hit[HOLD_OCR])
            begin
                n.rd_data = async_clock_select ? s.hold[HOLD_OCR] : s.ocr_buf;
            end
            if (hit[HOLD_CNT])
            begin
                n.rd_data = s.cnt;
            end
            if (hit[HOLD_CTRL])
            begin
                n.rd_data = (async_clock_select ? s.hold[HOLD_CTRL] : s.ctrl) & ~FOC_MASK;
            end
        end
        n.pin_out = (n.ctrl[COM_HI:COM_LO] != ACT_NONE) ? n.oc : port_data;
        n.pin_oe_n = ~port_dir;
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            s <= '0;
            s.cnt <= COUNTER_RESET;
            s.ocr_buf <= COMPARE_RESET;
            s.ocr_act <= COMPARE_RESET;
            s.ctrl <= CONTROL_RESET;
            s.pin_oe_n <= 1'b1;
        end
        else if (clk_en)
        begin
            s <= n;
        end
    end

    assign rd_data = s.rd_data;
    assign compare_output_pin = s.pin_out;
    assign compare_output_oe_n = s.pin_oe_n;
    assign compare_match_event = s.cmp_evt;
    assign overflow_event = s.ovf_evt;
    assign counter_update_busy = s.busy[HOLD_CNT];
    assign compare_update_busy = s.busy[HOLD_OCR];
    assign control_update_busy = s.busy[HOLD_CTRL];

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    foc_read_zero_a: assert property (
        clk_en && io_req.rd && hit[HOLD_CTRL] |=> rd_data[FOC_BIT] == 1'b0)
        else $error("force strobe read back as one");
    force_no_event_a: assert property (
        clk_en && force_now && !tick |=> !compare_match_event && $stable(s.cnt))
        else $error("forced compare raised an event or moved the counter");
    pwm_force_none_a: assert property (
        clk_en && !async_clock_select && io_req.wr && hit[HOLD_CTRL]
        && io_req.wdata[FOC_BIT] && io_req.wdata[WAVE_LOW_BIT] && !tick
        |=> $stable(s.oc))
        else $error("force strobe acted in a PWM mode");
    ctc_clear_a: assert property (
        clk_en && tick && mode == MODE_CTC && match && !apply[HOLD_CNT]
        |=> s.cnt == COUNT_BOTTOM && compare_match_event)
        else $error("clear-on-match did not clear the counter");
    normal_wrap_a: assert property (
        clk_en && tick && mode == MODE_NORMAL && s.cnt == COUNT_MAX && !apply[HOLD_CNT]
        |=> s.cnt == COUNT_BOTTOM && overflow_event)
        else $error("normal mode did not wrap with overflow");
    write_block_a: assert property (
        clk_en && !async_clock_select && io_req.wr && hit[HOLD_CNT]
        ##1 (clk_en && tick) |=> !compare_match_event)
        else $error("match seen on tick after counter write");
    pin_override_a: assert property (
        s.ctrl[COM_HI:COM_LO] != ACT_NONE |-> compare_output_pin == s.oc)
        else $error("compare output did not own the pin");
    pin_enable_a: assert property (
        clk_en |=> compare_output_oe_n == !$past(port_dir))
        else $error("pin enable does not follow the direction bit");
    async_busy_a: assert property (
        clk_en && async_clock_select && io_req.wr && hit[HOLD_CTRL]
        |=> control_update_busy)
        else $error("asynchronous control write did not set busy");
    fast_bottom_a: assert property (
        clk_en && tick && mode == MODE_FAST && s.cnt == COUNT_MAX
        && com == ACT_CLEAR && !force_now |=> s.oc)
        else $error("fast PWM non-inverting did not set at bottom");
endmodule : timer8_pwm_compare

//--- timer8_pwm_compare_bench.sv
`timescale 1ns/1ps

module timer8_pwm_compare_bench;
    import timer8_pkg::*;
    localparam logic [1:0] COMS [4] = '{2'h3, 2'h1, 2'h1, 2'h2};
    localparam logic PINS [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    localparam int DIVS [8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    bus_req_t io_req = '0;
    logic [7:0] rd_data;
    logic async_sel = 1'b0;
    logic xtal = 1'b0;
    logic xtal_run = 1'b0;
    logic port_data = 1'b0;
    logic port_dir = 1'b0;
    logic pin, oe_n, cmp_evt, ovf_evt, cnt_busy, cmp_busy, ctl_busy;
    logic clr = 1'b0;
    logic wire_level;
    logic taken = 1'b0;
    int unsigned high_count;
    int bad_count = 0;
    int comparisons = 0;
    int cyc = 0;
    int cmp_seen = 0;
    logic [7:0] exp_q[$];

    always #25 mclk = ~mclk;
    // crystal runs unrelated in phase to mclk
    always #173 if (xtal_run) xtal = ~xtal;

    timer8_pwm_compare #(.XFER_EDGES(2)) timer8_pwm_compare_inst (
        .mclk(mclk), .rst_n(rst_n), .clk_en(1'b1), .io_req(io_req), .rd_data(rd_data),
        .async_clock_select(async_sel), .crystal_clock_pin(xtal),
        .port_data(port_data), .port_dir(port_dir), .compare_output_pin(pin),
        .compare_output_oe_n(oe_n), .compare_match_event(cmp_evt),
        .overflow_event(ovf_evt), .counter_update_busy(cnt_busy),
        .compare_update_busy(cmp_busy), .control_update_busy(ctl_busy));

    pin_load_model pin_load_model_inst (.mclk(mclk), .pin(pin), .oe_n(oe_n),
        .clear_count(clr), .wire_level(wire_level), .high_count(high_count));

    task automatic check_rd(input logic [7:0] exp);
        comparisons++;
        if (rd_data !== exp)
        begin
            bad_count++;
            $display("[FAIL] rd_data expected %h seen %h", exp, rd_data);
        end
    endtask : check_rd

    task automatic check_val(input string nm, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[FAIL] %s expected %0d seen %0d", nm, exp, got);
        end
    endtask : check_val

    // read results appear on the taking edge and are checked at the next falling edge
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        taken <= rst_n && io_req.rd;
        if (cmp_evt === 1'b1)
            cmp_seen <= cmp_seen + 1;
    end

    always @(negedge mclk)
        if (taken)
            check_rd(exp_q.pop_front());

    task automatic bus(input logic w, input logic [7:0] a, input logic io, input logic [7:0] d);
        @(posedge mclk);
        io_req <= '{wr: w, rd: !w, io_space: io, addr: io ? a : a + DATA_SPACE_OFFSET, wdata: d};
        @(posedge mclk);
        io_req <= '0;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic io = 1'b1);
        bus(1'b1, a, io, d);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic io = 1'b1);
        exp_q.push_back(exp);
        bus(1'b0, a, io, 8'h00);
    endtask : rd

    task automatic pin_check(input logic exp);
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        check_val("pin level", {15'h0000, exp}, {15'h0000, wire_level});
    endtask : pin_check

    task automatic wait_pulse(input logic ovf, output int t);
        t = 0;
        for (int i = 0; i < 6000; i++)
        begin
            @(negedge mclk);
            if ((ovf ? ovf_evt : cmp_evt) === 1'b1)
            begin
                t = cyc;
                return;
            end
        end
        check_val("pulse wait", 16'h0001, 16'h0000);
    endtask : wait_pulse

    task automatic duty(input int n, output int h);
        @(posedge mclk);
        clr <= 1'b1;
        @(posedge mclk);
        clr <= 1'b0;
        repeat (n) @(posedge mclk);
        @(negedge mclk);
        h = high_count;
    endtask : duty

    function automatic logic busy_of(input int r);
        return r == 0 ? cmp_busy : (r == 1 ? cnt_busy : ctl_busy);
    endfunction : busy_of

    task automatic done(input string nm);
        $display("test %s done", nm);
    endtask : done

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop

    initial
    begin : watchdog
        repeat (60000) @(posedge mclk);
        bad_count++;
        report_and_stop();
    end

    initial
    begin : main
        int t0, t1, h0, h1, c0, n;
        logic [7:0] v;
        logic [7:0] a;
        void'($urandom(68920));
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        for (int i = 0; i < 3; i++)
            rd(ADDR_COMPARE + 8'(i), 8'h00);
        done("reset values");
        for (int s = 0; s < 2; s++)
        begin
            v = 8'($urandom);
            wr(ADDR_COMPARE, v, s[0]);
            rd(ADDR_COMPARE, v, s[0]);
            wr(ADDR_COUNTER, ~v, s[0]);
            wr(ADDR_CONTROL, {!v[6], v[6:3], CS_STOP}, s[0]);
            rd(ADDR_CONTROL, {1'b0, v[6:3], CS_STOP}, s[0]);
            rd(ADDR_COUNTER, ~v, s[0]);
        end
        rd(8'h40, 8'h00);
        rd(8'h10, 8'h00, 1'b0);
        rd(8'h40, 8'h00, 1'b0);
        done("register access");
        port_dir <= 1'b1;
        wr(ADDR_COUNTER, 8'h05);
        wr(ADDR_COMPARE, 8'h05);
        c0 = cmp_seen;
        for (int i = 0; i < 4; i++)
        begin
            wr(ADDR_CONTROL, {1'b1, 1'b0, COMS[i], i[0], CS_STOP});
            pin_check(PINS[i]);
        end
        wr(ADDR_CONTROL, {1'b1, 1'b1, 2'h3, 1'b1, CS_STOP});
        pin_check(1'b0);
        wr(ADDR_CONTROL, {1'b1, 1'b1, 2'h3, 1'b0, CS_STOP});
        pin_check(1'b0);
        check_val("force events", 16'h0000, 16'(cmp_seen - c0));
        rd(ADDR_COUNTER, 8'h05);
        done("force compare");
        v = 8'($urandom);
        wr(ADDR_CONTROL, 8'h00);
        port_data <= v[0];
        pin_check(v[0]);
        port_dir <= 1'b0;
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        check_val("oe_n", 16'h0001, {15'h0000, oe_n});
        @(posedge mclk);
        port_dir <= 1'b1;
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        check_val("oe_n", 16'h0000, {15'h0000, oe_n});
        @(posedge mclk);
        done("pin override");
        wr(ADDR_COUNTER, 8'h00);
        wr(ADDR_COMPARE, 8'h01);
        for (int cs = 1; cs < 8; cs++)
        begin
            wr(ADDR_CONTROL, {5'h01, 3'(cs)});
            wait_pulse(1'b0, t0);
            wait_pulse(1'b0, t0);
            wait_pulse(1'b0, t1);
            check_val("ctc period", 16'(2 * DIVS[cs]), 16'(t1 - t0));
        end
        done("clock select");
        wr(ADDR_COMPARE, 8'h80);
        for (int p = 0; p < 2; p++)
        begin
            n = p ? 510 : 256;
            wr(ADDR_CONTROL, {1'b0, 1'b1, 2'h2, !p[0], CS_DIV1});
            wait_pulse(1'b1, t0);
            wait_pulse(1'b1, t1);
            check_val("ovf period", 16'(n), 16'(t1 - t0));
            duty(n, h0);
            check_val("duty", p ? 16'h0020 : 16'h0010, 16'((h0 + 4) >> 3));
            wr(ADDR_CONTROL, {1'b0, 1'b1, 2'h3, !p[0], CS_DIV1});
            wait_pulse(1'b1, t0);
            duty(n, h1);
            check_val("duty sum", 16'(n), 16'(h0 + h1));
        end
        wr(ADDR_CONTROL, {1'b0, 1'b1, 2'h2, 1'b1, CS_DIV1});
        wr(ADDR_COMPARE, COUNT_MAX);
        wait_pulse(1'b1, t0);
        wait_pulse(1'b1, t0);
        duty(256, h0);
        check_val("top duty", 16'h0100, 16'(h0));
        done("pwm modes");
        wr(ADDR_CONTROL, {5'h00, CS_DIV1});
        wr(ADDR_COMPARE, 8'h10);
        wr(ADDR_COUNTER, 8'h80);
        wr(ADDR_COUNTER, 8'h10);
        c0 = cmp_seen;
        repeat (100) @(posedge mclk);
        check_val("blocked match", 16'h0000, 16'(cmp_seen - c0));
        wait_pulse(1'b0, t0);
        done("counter write");
        wr(ADDR_CONTROL, 8'h00);
        async_sel <= 1'b1;
        xtal_run <= 1'b1;
        for (int r = 0; r < 3; r++)
        begin
            a = ADDR_COMPARE + 8'(r);
            v = 8'($urandom) & 8'h78;
            wr(a, v);
            @(negedge mclk);
            check_val("busy set", 16'h0001, {15'h0000, busy_of(r)});
            if (r != 1)
                rd(a, v);
            for (int i = 0; i < 400 && busy_of(r) === 1'b1; i++)
                @(posedge mclk);
            check_val("busy clear", 16'h0000, {15'h0000, busy_of(r)});
            rd(a, v);
        end
        async_sel <= 1'b0;
        xtal_run <= 1'b0;
        done("async transfer");
        report_and_stop();
    end
endmodule : timer8_pwm_compare_bench
